// *** spimsc_pkg.sv ***
// Package for the serial master/slave core: shared constants and carrier types.
// Assumes a single 25 MHz bus clock with synchronous active-high reset.
package spimsc_pkg;
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned BYTE_BITS   = 8;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  // Half-period of serial clock in bus cycles, per rate select code
  localparam logic [6:0]  HALF_DIV2   = 7'h01;
  localparam logic [6:0]  HALF_DIV8   = 7'h04;
  localparam logic [6:0]  HALF_DIV32  = 7'h10;
  localparam logic [6:0]  HALF_DIV128 = 7'h40;
  localparam logic [6:0]  HALF_ONE    = 7'h01;
  localparam logic [1:0]  RATE_DIV2   = 2'h0;
  localparam logic [1:0]  RATE_DIV8   = 2'h1;
  localparam logic [1:0]  RATE_DIV32  = 2'h2;
  localparam logic [1:0]  RATE_DIV128 = 2'h3;

  typedef struct packed {
    logic       module_enable_bit;
    logic       master_select_bit;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic       clock_rate_select_hi;
    logic       clock_rate_select_lo;
    logic       rx_irq_enable;
    logic       tx_irq_enable;
    logic       error_irq_enable;
  } spimsc_ctrl_s;

  typedef struct packed {
    logic rx_full_flag;
    logic tx_empty_flag;
    logic overflow_flag;
    logic mode_fault_flag;
    logic busy;
  } spimsc_stat_s;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spimsc_pins_s;
endpackage

// *** spimsc_rate_gen.sv ***
// Free-running serial bit-rate tick generator for master mode.
// Assumes one bus clock; emits one-cycle half-bit enable pulses.
`timescale 1ns/1ps
`default_nettype none
module spimsc_rate_gen
  import spimsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] rate_sel,
  output logic            half_tick
);
  logic [6:0] count;
  logic [6:0] next_count;
  logic [6:0] half_len;

  always_comb begin
    unique case (rate_sel)
      RATE_DIV2:  half_len = HALF_DIV2;
      RATE_DIV8:  half_len = HALF_DIV8;
      RATE_DIV32: half_len = HALF_DIV32;
      default:    half_len = HALF_DIV128;
    endcase
  end

  // Stopped unless enabled as master, to save power
  always_comb begin
    next_count = count;
    half_tick  = 1'b0;
    if (!run) begin
      next_count = 7'h00;
    end else if (count + HALF_ONE >= half_len) begin
      next_count = 7'h00;
      half_tick  = 1'b1;
    end else begin
      next_count = count + HALF_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 7'h00;
    end else begin
      count <= next_count;
    end
  end
endmodule // spimsc_rate_gen
`default_nettype wire

// *** spimsc_core.sv ***
// Full-duplex serial port core, master or slave, with double-buffered data.
// Assumes pins are synchronous to clk; slave clock at most half bus rate.
//
// Overview of operation
// - Master when master select set; slave takes serial clock as input.
// - Only a master starts transfers; a data write starts one.
// - Separate tx and rx buffers; write into empty shifter moves at once.
// - Four master rates from bus clock, fastest bus divided by two.
// - Master shifts in from slave while shifting out, same clock.
// - Byte end sets receive full and moves shifter into receive buffer.
// - Receive full clears by status read while set, then data read.
// - A data write that cannot enter the shifter at once clears transmit empty until it does.
// - Slave samples under external clock; byte end sets receive full.
// - Overflow error flag with interrupt capability.
// - Mode fault flag; master sees slave select low as contention.
// - Slave accepts any serial clock up to half the bus clock rate.
// - Slave shifts its shifter out; late byte means received byte sent back.
// - Slave byte written mid-transfer waits until transfer end.
// - Slave start: first clock edge if phase set, else select fall.
// - Separately enabled receive-full and transmit-empty interrupts.
// - Software selectable clock polarity and phase, four combinations.
// - Unselected slave leaves its data output undriven.
// - Phase clear: slave select toggles high between bytes.
// - Master write-to-start delay at most one bit time.
// - Master clock generator runs only when enabled and master.
// - Queued master byte starts right after previous transfer.
`timescale 1ns/1ps
`default_nettype none
module spimsc_core
  import spimsc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire spimsc_ctrl_s ctrl,
  input  wire logic         data_write,
  input  wire logic [7:0]   data_wdata,
  input  wire logic         data_read,
  input  wire logic         status_read,
  input  wire logic         error_clear,
  output logic [7:0]        rx_data,
  output spimsc_stat_s      status,
  output logic              irq,
  input  wire logic         sclk_i,
  input  wire logic         slave_select_n,
  input  wire logic         mosi_i,
  input  wire logic         miso_i,
  output spimsc_pins_s      pins
);
  typedef enum logic [2:0] {
    SPIMSC_IDLE = 3'b001,
    SPIMSC_LEAD = 3'b010,
    SPIMSC_TRAIL = 3'b100
  } spimsc_state_e;

  spimsc_state_e state, next_state;
  logic [7:0] shifter, next_shifter;
  logic [7:0] tx_buf, next_tx_buf;
  logic [7:0] rx_buf, next_rx_buf;
  logic [2:0] bit_idx, next_bit_idx;
  logic       tx_full, next_tx_full;
  logic       rxf, next_rxf;
  logic       armed, next_armed;
  logic       ovf, next_ovf;
  logic       modf, next_modf;
  logic       pend, next_pend;
  logic       sclk_q, next_sclk_q;
  logic       ss_q, sclk_d;
  logic       sample_bit, next_sample_bit;
  logic       sclk_out, next_sclk_out;
  logic       half_tick;
  logic       en_master, en_slave;
  logic       lead_edge, trail_edge;
  logic       byte_done;
  logic       rx_in;

  assign en_master = ctrl.module_enable_bit && ctrl.master_select_bit;
  assign en_slave  = ctrl.module_enable_bit && !ctrl.master_select_bit;
  assign rx_in     = en_master ? miso_i : mosi_i;

  spimsc_rate_gen u_rate (
    .clk       (clk),
    .reset     (reset),
    .run       (en_master),
    .rate_sel  ({ctrl.clock_rate_select_hi, ctrl.clock_rate_select_lo}),
    .half_tick (half_tick)
  );

  // Slave edges: pins are bus-synchronous so a one-flop history is enough
  always_ff @(posedge clk) begin
    if (reset) begin
      ss_q   <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      ss_q   <= slave_select_n;
      sclk_d <= sclk_i;
    end
  end

  // Leading edge leaves idle level; polarity picks idle level
  always_comb begin
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    if (en_slave && !slave_select_n && (sclk_i != sclk_d)) begin
      lead_edge  = (sclk_d == ctrl.clock_polarity_bit);
      trail_edge = !lead_edge;
    end
  end

  always_comb begin
    next_state      = state;
    next_shifter    = shifter;
    next_tx_buf     = tx_buf;
    next_rx_buf     = rx_buf;
    next_bit_idx    = bit_idx;
    next_tx_full    = tx_full;
    next_rxf        = rxf;
    next_armed      = armed;
    next_ovf        = ovf;
    next_modf       = modf;
    next_pend       = pend;
    next_sample_bit = sample_bit;
    next_sclk_out   = sclk_out;
    next_sclk_q     = sclk_q;
    byte_done       = 1'b0;

    // Read sequence to clear receive full; arm is lost if flag drops
    if (status_read && rxf) begin
      next_armed = 1'b1;
    end
    if (data_read && armed) begin
      next_rxf   = 1'b0;
      next_armed = 1'b0;
    end
    if (error_clear) begin
      next_ovf  = 1'b0;
      next_modf = 1'b0;
    end

    if (data_write) begin
      next_tx_buf  = data_wdata;
      next_tx_full = 1'b1;
    end

    // Slave select low on a master means another master drives the bus
    if (en_master && !slave_select_n) begin
      next_modf = 1'b1;
    end

    unique case (state)
      SPIMSC_IDLE: begin
        next_sclk_out = ctrl.clock_polarity_bit;
        next_bit_idx  = BIT_FIRST;
        // Buffered byte drops into an idle shifter at once, unless one waits unsent
        if (next_tx_full && ctrl.module_enable_bit && !pend) begin
          next_shifter = next_tx_buf;
          next_tx_full = 1'b0;
          next_pend    = 1'b1;
        end
        // Pending byte waits for the free-running tick, so delay stays under a bit
        if (en_master && !next_modf && next_pend && half_tick) begin
          next_state = SPIMSC_LEAD;
          next_pend  = 1'b0;
          if (ctrl.clock_phase_bit) begin
            next_sclk_out = !ctrl.clock_polarity_bit;
          end
        end else if (en_slave && !slave_select_n &&
                     ((!ctrl.clock_phase_bit && ss_q) ||
                      (ctrl.clock_phase_bit && lead_edge))) begin
          next_state = SPIMSC_LEAD;
          next_pend  = 1'b0;
        end
      end
      SPIMSC_LEAD: begin
        // First half bit: both phases sample at its end
        if (en_master && half_tick) begin
          next_sclk_out = !next_sclk_out;
          if (ctrl.clock_phase_bit) begin
            next_sample_bit = rx_in;
            next_state      = SPIMSC_TRAIL;
          end else begin
            next_sample_bit = rx_in;
            next_state      = SPIMSC_TRAIL;
          end
        end else if (en_slave && (ctrl.clock_phase_bit ? trail_edge : lead_edge)) begin
          next_sample_bit = rx_in;
          next_state      = SPIMSC_TRAIL;
        end
      end
      SPIMSC_TRAIL: begin
        // Phase set: no leading edge follows the last bit, so finish at once
        if ((en_master && half_tick) ||
            (en_slave && (ctrl.clock_phase_bit ? (lead_edge || bit_idx == BIT_LAST)
                                               : trail_edge))) begin
          next_shifter = {shifter[6:0], sample_bit};
          if (bit_idx == BIT_LAST) begin
            byte_done     = 1'b1;
            next_state    = SPIMSC_IDLE;
            next_sclk_out = ctrl.clock_polarity_bit;
          end else begin
            next_bit_idx = bit_idx + 3'h1;
            next_state   = SPIMSC_LEAD;
            if (en_master) begin
              next_sclk_out = !sclk_out;
            end
          end
        end
      end
      default: next_state = SPIMSC_IDLE;
    endcase

    if (byte_done) begin
      next_rx_buf = {shifter[6:0], sample_bit};
      next_rxf    = 1'b1;
      if (rxf) begin
        next_ovf = 1'b1;
      end
    end
    // Disabling aborts any frame in flight
    if (!ctrl.module_enable_bit || (en_master && next_modf)) begin
      next_state = SPIMSC_IDLE;
    end
    if (!ctrl.module_enable_bit) begin
      next_pend = 1'b0;
    end
    next_sclk_q = next_sclk_out;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state      <= SPIMSC_IDLE;
      shifter    <= 8'h00;
      tx_buf     <= 8'h00;
      rx_buf     <= 8'h00;
      bit_idx    <= 3'h0;
      tx_full    <= 1'b0;
      rxf        <= 1'b0;
      armed      <= 1'b0;
      ovf        <= 1'b0;
      modf       <= 1'b0;
      pend       <= 1'b0;
      sample_bit <= 1'b0;
      sclk_out   <= 1'b0;
      sclk_q     <= 1'b0;
    end else begin
      state      <= next_state;
      shifter    <= next_shifter;
      tx_buf     <= next_tx_buf;
      rx_buf     <= next_rx_buf;
      bit_idx    <= next_bit_idx;
      tx_full    <= next_tx_full;
      rxf        <= next_rxf;
      armed      <= next_armed;
      ovf        <= next_ovf;
      modf       <= next_modf;
      pend       <= next_pend;
      sample_bit <= next_sample_bit;
      sclk_out   <= next_sclk_out;
      sclk_q     <= next_sclk_q;
    end
  end

  assign rx_data               = rx_buf;
  assign status.rx_full_flag   = rxf;
  assign status.tx_empty_flag  = !tx_full;
  assign status.overflow_flag  = ovf;
  assign status.mode_fault_flag = modf;
  assign status.busy           = (state != SPIMSC_IDLE);
  assign irq = (ctrl.rx_irq_enable && rxf) || (ctrl.tx_irq_enable && !tx_full) ||
               (ctrl.error_irq_enable && (ovf || modf));

  // Msb goes out first; phase set holds it until leading edge
  assign pins.sclk_o  = sclk_q;
  assign pins.sclk_oe = en_master;
  assign pins.mosi_o  = shifter[BYTE_BITS-1];
  assign pins.mosi_oe = en_master;
  assign pins.miso_o  = shifter[BYTE_BITS-1];
  assign pins.miso_oe = en_slave && !slave_select_n;

  a_rx_full_set: assert property (@(posedge clk) disable iff (reset)
    byte_done |=> rxf && rx_data == $past(next_rx_buf))
    else $error("receive full not set at byte end");
  a_rx_clear_seq: assert property (@(posedge clk) disable iff (reset)
    $fell(rxf) |-> $past(data_read) && $past(armed))
    else $error("receive full cleared without read sequence");
  a_tx_write_clr: assert property (@(posedge clk) disable iff (reset)
    data_write && state != SPIMSC_IDLE |=> !status.tx_empty_flag)
    else $error("write did not clear transmit empty");
  a_overflow_set: assert property (@(posedge clk) disable iff (reset)
    byte_done && rxf && !data_read |=> ovf)
    else $error("overflow not flagged");
  a_miso_release: assert property (@(posedge clk) disable iff (reset)
    slave_select_n |-> !pins.miso_oe)
    else $error("unselected slave drives data line");
  a_slave_no_start: assert property (@(posedge clk) disable iff (reset)
    !en_master && slave_select_n && state == SPIMSC_IDLE |=> state == SPIMSC_IDLE)
    else $error("transfer began without master or select");
  a_master_start: assert property (@(posedge clk) disable iff (reset)
    en_master && !modf && slave_select_n && state == SPIMSC_IDLE && data_write && !pend &&
    ctrl.clock_rate_select_hi == 1'b0 && ctrl.clock_rate_select_lo == 1'b0
    |-> ##[1:2] state != SPIMSC_IDLE || !en_master || !slave_select_n)
    else $error("master start delayed over one bit");
  a_sclk_idle: assert property (@(posedge clk) disable iff (reset)
    state == SPIMSC_IDLE ##1 state == SPIMSC_IDLE |-> sclk_q == $past(ctrl.clock_polarity_bit))
    else $error("serial clock not at idle level");
endmodule // spimsc_core
`default_nettype wire

// *** spimsc_peer.sv ***
// Far-end peer: a slave that answers the core as master, or a master
// with its own clock for slave tests. The slave side acts on serial clock edges.
`timescale 1ns/1ps
`default_nettype none
module spimsc_peer (
  input  wire logic clk,
  input  wire logic acting_slave,
  input  wire logic pol,
  input  wire logic pha,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic miso,
  output logic      p_sclk,
  output logic      p_mosi,
  output logic      p_miso,
  output logic      ss_n
);
  logic [7:0] s_tx = 8'h00;
  logic [7:0] s_rx = 8'h00;
  initial p_sclk = 1'b0;
  initial p_mosi = 1'b0;
  initial ss_n = 1'b1;
  // Released line shows the opposite level so stale data never matches
  assign p_miso = acting_slave ? s_tx[7] : ~s_tx[7];
  // Reacts on the edge itself; a bus-clock sampler would lag a full cycle at top rate
  always @(sclk) begin
    if (acting_slave && sclk != pol && !pha) s_rx <= {s_rx[6:0], mosi};
    if (acting_slave && sclk == pol) begin
      s_tx <= {s_tx[6:0], s_tx[7]};
      if (pha) s_rx <= {s_rx[6:0], mosi};
    end
  end
  // Entered and left at a rising clock edge
  task automatic xfer(input logic [7:0] tx, input logic pha, input int half,
                      input logic keep, output logic [7:0] rx);
    if (ss_n) begin
      ss_n <= 1'b0;
      repeat (3) @(posedge clk);
    end
    for (int i = 7; i >= 0; i--) begin
      if (!pha) p_mosi <= tx[i];
      if (!pha) repeat (half) @(posedge clk);
      p_sclk <= ~pol;
      if (pha) p_mosi <= tx[i];
      repeat (half) @(posedge clk);
      rx[i] = miso;
      p_sclk <= pol;
      if (pha) repeat (half) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    p_mosi <= ~p_mosi;
    if (!keep) ss_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule // spimsc_peer
`default_nettype wire

// *** spimsc_core_tb.sv ***
// Testbench: master rates and queueing, receive flag handshake, errors,
// slave transfers. Assumes the package and peer model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %s", $time, m); end end
module spimsc_core_tb
  import spimsc_pkg::*;
;
  logic         clk;
  logic         reset;
  spimsc_ctrl_s ctrl;
  logic         data_write;
  logic [7:0]   data_wdata;
  logic         data_read;
  logic         status_read;
  logic         error_clear;
  logic [7:0]   rx_data;
  spimsc_stat_s status;
  logic         irq;
  spimsc_pins_s pins;
  logic         act_slave;
  logic         p_sclk, p_mosi, p_miso, ss_n, sclk_l, mosi_l, miso_l;
  int           n_fail = 0;
  int           check_count = 0;
  int           cycles = 0;
  assign sclk_l = pins.sclk_oe ? pins.sclk_o : p_sclk;
  assign mosi_l = pins.mosi_oe ? pins.mosi_o : p_mosi;
  assign miso_l = pins.miso_oe ? pins.miso_o : p_miso;
  spimsc_core dut (.clk(clk), .reset(reset), .ctrl(ctrl), .data_write(data_write),
    .data_wdata(data_wdata), .data_read(data_read), .status_read(status_read),
    .error_clear(error_clear), .rx_data(rx_data), .status(status), .irq(irq),
    .sclk_i(sclk_l), .slave_select_n(ss_n), .mosi_i(mosi_l), .miso_i(miso_l), .pins(pins));
  spimsc_peer far (.clk(clk), .acting_slave(act_slave), .pol(ctrl.clock_polarity_bit),
    .pha(ctrl.clock_phase_bit),
    .sclk(sclk_l), .mosi(mosi_l), .miso(miso_l), .p_sclk(p_sclk), .p_mosi(p_mosi),
    .p_miso(p_miso), .ss_n(ss_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run is near 2k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      stop_test;
    end
  end
  task automatic wr(input logic [7:0] b);
    data_write <= 1'b1;
    data_wdata <= b;
    @(posedge clk);
    data_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic strobe(input logic s, input logic d, input logic e);
    status_read <= s;
    data_read <= d;
    error_clear <= e;
    @(posedge clk);
    status_read <= 1'b0;
    data_read <= 1'b0;
    error_clear <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_flag(input logic ovf, input int lim);
    int n;
    n = 0;
    while ((ovf ? status.overflow_flag : status.rx_full_flag) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < lim, 1'b1, "flag never set")
  endtask
  // Mode is set while disabled, then the port is enabled
  task automatic cfg(input logic mst, input logic pol, input logic pha, input logic [1:0] r);
    ctrl <= '{master_select_bit: mst, clock_polarity_bit: pol, clock_phase_bit: pha,
      clock_rate_select_hi: r[1], clock_rate_select_lo: r[0], rx_irq_enable: 1'b1,
      default: 1'b0};
    far.p_sclk <= pol;
    repeat (2) @(posedge clk);
    ctrl.module_enable_bit <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    logic [7:0] got;
    logic [7:0] exp;
    int n;
    int h;
    ctrl = '0;
    data_write = 1'b0;
    data_wdata = 8'h00;
    data_read = 1'b0;
    status_read = 1'b0;
    error_clear = 1'b0;
    act_slave = 1'b0;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(status.tx_empty_flag, 1'b1, "tx empty after reset")
    `CHK(status.rx_full_flag, 1'b0, "rx full after reset")
    act_slave <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      h = 4 ** r;
      cfg(1'b1, r[0], r[1], r[1:0]);
      `CHK(pins.sclk_oe, 1'b1, "master drives clock")
      `CHK(pins.sclk_o, r[0], "clock idle level")
      exp = 8'h5a ^ 8'(r);
      far.s_tx <= exp;
      wr(8'hc3 + 8'(r));
      n = 1;
      while (pins.sclk_o === r[0] && n < 300) begin
        @(posedge clk);
        n++;
      end
      `CHK(n <= 2 * h + 3, 1'b1, "start delay too long")
      n = 0;
      while (pins.sclk_o !== r[0] && n < 300) begin
        @(posedge clk);
        n++;
      end
      `CHK(n, h, "clock half period")
      wait_flag(1'b0, 40 * h);
      `CHK(rx_data, exp, "master byte in")
      `CHK(far.s_rx, 8'hc3 + 8'(r), "master byte out")
      `CHK(irq, 1'b1, "rx interrupt")
      strobe(1'b0, 1'b1, 1'b0);
      `CHK(status.rx_full_flag, 1'b1, "data read alone")
      strobe(1'b1, 1'b0, 1'b0);
      strobe(1'b0, 1'b1, 1'b0);
      `CHK(status.rx_full_flag, 1'b0, "rx full cleared")
      `CHK(irq, 1'b0, "tx interrupt masked")
      $display("rate test %0d done", r);
    end
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    far.s_tx <= 8'h96;
    wr(8'h11);
    wr(8'h22);
    `CHK(status.tx_empty_flag, 1'b0, "byte queued")
    wait_flag(1'b0, 100);
    `CHK(rx_data, 8'h96, "first byte in")
    repeat (2) @(posedge clk);
    `CHK(status.tx_empty_flag, 1'b1, "queued byte loaded")
    wait_flag(1'b1, 100);
    `CHK(far.s_rx, 8'h22, "queued byte out")
    strobe(1'b0, 1'b0, 1'b1);
    `CHK(status.overflow_flag, 1'b0, "overflow cleared")
    strobe(1'b1, 1'b0, 1'b0);
    strobe(1'b0, 1'b1, 1'b0);
    $display("queue test done");
    ctrl.error_irq_enable <= 1'b1;
    far.ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(status.mode_fault_flag, 1'b1, "contention seen")
    `CHK(irq, 1'b1, "fault interrupt")
    far.ss_n <= 1'b1;
    strobe(1'b0, 1'b0, 1'b1);
    `CHK(status.mode_fault_flag, 1'b0, "fault cleared")
    `CHK(irq, 1'b0, "fault interrupt cleared")
    ctrl.tx_irq_enable <= 1'b1;
    @(posedge clk);
    `CHK(irq, 1'b1, "tx empty interrupt")
    $display("fault test done");
    act_slave <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      cfg(1'b0, p[0], p[0], 2'h0);
      `CHK(pins.sclk_oe, 1'b0, "slave clock is input")
      `CHK(pins.miso_oe, 1'b0, "unselected slave quiet")
      wr(8'hb4 ^ 8'(p));
      fork
        far.xfer(8'h3d + 8'(p), p[0], 2 + p, p[0], got);
        begin
          repeat (12) @(posedge clk);
          wr(8'h69);
        end
      join
      `CHK(got, 8'hb4 ^ 8'(p), "slave byte out")
      `CHK(rx_data, 8'h3d + 8'(p), "slave byte in")
      strobe(1'b1, 1'b0, 1'b0);
      strobe(1'b0, 1'b1, 1'b0);
      far.xfer(8'hc7, p[0], 2 + p, 1'b0, got);
      `CHK(got, 8'h69, "held byte sent next")
      `CHK(rx_data, 8'hc7, "second slave byte in")
      `CHK(pins.miso_oe, 1'b0, "released after frame")
      strobe(1'b1, 1'b0, 1'b0);
      strobe(1'b0, 1'b1, 1'b0);
      $display("slave test %0d done", p);
    end
    stop_test;
  end
endmodule // spimsc_core_tb
`default_nettype wire
